// file: src/eiep_pkg.sv
package eiep_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE_ONE   = 8'hE6;
    localparam logic [7:0] ADDR_ENABLE_TWO   = 8'hE7;
    localparam logic [7:0] ADDR_PRIORITY_ONE = 8'hE8;
    localparam logic [7:0] ADDR_EVT_STATUS   = 8'hE9;
    localparam logic [7:0] ADDR_EVT_MASK     = 8'hEA;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int BIT_TIMER3      = 7;
    localparam int BIT_COMPARATOR1 = 6;
    localparam int BIT_COMPARATOR0 = 5;
    localparam int BIT_COUNTER_ARR = 4;
    localparam int BIT_CONV_DONE   = 3;
    localparam int BIT_WINDOW_CMP  = 2;
    localparam int BIT_SMBUS       = 0;
    localparam int BIT_PORT_MATCH  = 1;

    localparam logic [7:0] ONE_WRITABLE   = 8'hFD;
    localparam logic [7:0] TWO_WRITABLE   = 8'h02;
    localparam logic [7:0] RESET_ENABLE   = 8'h00;
    localparam logic [7:0] RESET_PRIORITY = 8'h00;
    localparam logic [7:0] RESET_EVT      = 8'h00;

    // event status bits: request rose, high-priority request rose
    localparam int EVT_ANY_RISE   = 0;
    localparam int EVT_HIGH_RISE  = 1;
    localparam logic [7:0] EVT_WRITABLE = 8'h03;

    localparam int NUM_SRC = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } eiep_bus_req_t;

    typedef struct packed {
        logic timer3_low_overflow_flag;
        logic timer3_high_overflow_flag;
        logic comparator1_rise_flag;
        logic comparator1_fall_flag;
        logic comparator0_rise_flag;
        logic comparator0_fall_flag;
        logic counter_array_flag;
        logic conv_done_flag;
        logic window_cmp_flag;
        logic smbus_flag;
        logic port_match_flag;
    } eiep_flags_t;

endpackage

// file: src/eiep_top.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// - enable bit7 gates timer3 low/high overflow
// - enable bit6 gates comparator1 rise/fall flags
// - enable bit5 gates comparator0 rise/fall flags
// - enable bit4 gates counter array requests
// - enable bit3 gates conversion complete flag
// - enable bit2 gates window compare flag
// - enable one bit1 reads zero, ignores writes
// - enable bit0 gates SMBus requests
// - enable one resets to all zeros
// - enable two bit1 gates port match
// - enable two other bits read zero
// - priority bit set means high priority
module eiep_top
    import eiep_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire eiep_bus_req_t      bus_req,
    output logic [7:0]              bus_rdata,
    input  wire eiep_flags_t        flags,
    output logic [NUM_SRC-1:0]      irq_req,
    output logic [NUM_SRC-1:0]      irq_high,
    output logic                    any_req_high,
    output logic                    any_req_low,
    output logic                    irq_out
);

    logic [7:0]         enable_one_r;
    logic [7:0]         enable_two_r;
    logic [7:0]         priority_one_r;
    logic [7:0]         evt_status_r;
    logic [7:0]         evt_mask_r;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] enables;
    logic [NUM_SRC-1:0] prios;
    logic [NUM_SRC-1:0] req_nxt;
    logic [NUM_SRC-1:0] high_nxt;
    logic               any_prev_r;
    logic               high_prev_r;
    logic               any_now;
    logic               high_now;
    logic [7:0]         evt_set;
    logic [7:0]         evt_clr;
    logic [7:0]         rdata_nxt;
    logic               timer3_irq_en;
    logic               comparator1_irq_en;
    logic               comparator0_irq_en;
    logic               counter_array_irq_en;
    logic               conv_done_irq_en;
    logic               window_cmp_irq_en;
    logic               smbus_irq_en;
    logic               port_match_irq_en;
    logic               timer3_irq_prio;
    logic               comparator1_irq_prio;
    logic               comparator0_irq_prio;
    logic               counter_array_irq_prio;
    logic               conv_done_irq_prio;
    logic               window_cmp_irq_prio;
    logic               smbus_irq_prio;

    function automatic logic is_wr(input eiep_bus_req_t r,
                                   input logic [7:0] a);
        is_wr = r.wr && (r.addr == a);
    endfunction

    // unused bits never latch, so they read back as zero
    function automatic logic [7:0] wr_bits(input logic [7:0] d,
                                           input logic [7:0] keep);
        wr_bits = d & keep;
    endfunction

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            enable_one_r <= RESET_ENABLE;
        end
        else if (is_wr(bus_req, ADDR_ENABLE_ONE))
        begin
            enable_one_r <= wr_bits(bus_req.wdata, ONE_WRITABLE);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            enable_two_r <= RESET_ENABLE;
        end
        else if (is_wr(bus_req, ADDR_ENABLE_TWO))
        begin
            enable_two_r <= wr_bits(bus_req.wdata, TWO_WRITABLE);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            priority_one_r <= RESET_PRIORITY;
        end
        else if (is_wr(bus_req, ADDR_PRIORITY_ONE))
        begin
            priority_one_r <= wr_bits(bus_req.wdata, ONE_WRITABLE);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            evt_mask_r <= RESET_EVT;
        end
        else if (is_wr(bus_req, ADDR_EVT_MASK))
        begin
            evt_mask_r <= wr_bits(bus_req.wdata, EVT_WRITABLE);
        end
    end

    // ------------------------------------------------------------
    // named fields
    // ------------------------------------------------------------
    assign timer3_irq_en          = enable_one_r[BIT_TIMER3];
    assign comparator1_irq_en     = enable_one_r[BIT_COMPARATOR1];
    assign comparator0_irq_en     = enable_one_r[BIT_COMPARATOR0];
    assign counter_array_irq_en   = enable_one_r[BIT_COUNTER_ARR];
    assign conv_done_irq_en       = enable_one_r[BIT_CONV_DONE];
    assign window_cmp_irq_en      = enable_one_r[BIT_WINDOW_CMP];
    assign smbus_irq_en           = enable_one_r[BIT_SMBUS];
    assign port_match_irq_en      = enable_two_r[BIT_PORT_MATCH];
    assign timer3_irq_prio        = priority_one_r[BIT_TIMER3];
    assign comparator1_irq_prio   = priority_one_r[BIT_COMPARATOR1];
    assign comparator0_irq_prio   = priority_one_r[BIT_COMPARATOR0];
    assign counter_array_irq_prio = priority_one_r[BIT_COUNTER_ARR];
    assign conv_done_irq_prio     = priority_one_r[BIT_CONV_DONE];
    assign window_cmp_irq_prio    = priority_one_r[BIT_WINDOW_CMP];
    assign smbus_irq_prio         = priority_one_r[BIT_SMBUS];

    // ------------------------------------------------------------
    // source gating
    // ------------------------------------------------------------
    always_comb
    begin
        pending = '0;
        pending[BIT_TIMER3] = flags.timer3_low_overflow_flag
                            | flags.timer3_high_overflow_flag;
        pending[BIT_COMPARATOR1] = flags.comparator1_rise_flag
                                 | flags.comparator1_fall_flag;
        pending[BIT_COMPARATOR0] = flags.comparator0_rise_flag
                                 | flags.comparator0_fall_flag;
        pending[BIT_COUNTER_ARR] = flags.counter_array_flag;
        pending[BIT_CONV_DONE]   = flags.conv_done_flag;
        pending[BIT_WINDOW_CMP]  = flags.window_cmp_flag;
        pending[BIT_SMBUS]       = flags.smbus_flag;
        // slot 1 is free in the first bank, so port match reuses it
        pending[BIT_PORT_MATCH]  = flags.port_match_flag;
        enables = '0;
        enables[BIT_TIMER3]      = timer3_irq_en;
        enables[BIT_COMPARATOR1] = comparator1_irq_en;
        enables[BIT_COMPARATOR0] = comparator0_irq_en;
        enables[BIT_COUNTER_ARR] = counter_array_irq_en;
        enables[BIT_CONV_DONE]   = conv_done_irq_en;
        enables[BIT_WINDOW_CMP]  = window_cmp_irq_en;
        enables[BIT_SMBUS]       = smbus_irq_en;
        enables[BIT_PORT_MATCH]  = port_match_irq_en;
        // port match priority lives elsewhere; held low here
        prios = '0;
        prios[BIT_TIMER3]      = timer3_irq_prio;
        prios[BIT_COMPARATOR1] = comparator1_irq_prio;
        prios[BIT_COMPARATOR0] = comparator0_irq_prio;
        prios[BIT_COUNTER_ARR] = counter_array_irq_prio;
        prios[BIT_CONV_DONE]   = conv_done_irq_prio;
        prios[BIT_WINDOW_CMP]  = window_cmp_irq_prio;
        prios[BIT_SMBUS]       = smbus_irq_prio;
        req_nxt  = pending & enables;
        high_nxt = req_nxt & prios;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            irq_req <= '0;
        end
        else
        begin
            irq_req <= req_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            irq_high <= '0;
        end
        else
        begin
            irq_high <= high_nxt;
        end
    end

    assign any_req_high = |irq_high;
    assign any_req_low  = |(irq_req & ~irq_high);

    // ------------------------------------------------------------
    // event status and interrupt
    // ------------------------------------------------------------
    assign any_now  = |irq_req;
    assign high_now = |irq_high;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            any_prev_r <= 1'b0;
        end
        else
        begin
            any_prev_r <= any_now;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            high_prev_r <= 1'b0;
        end
        else
        begin
            high_prev_r <= high_now;
        end
    end

    always_comb
    begin
        evt_set = '0;
        evt_set[EVT_ANY_RISE]  = any_now && !any_prev_r;
        evt_set[EVT_HIGH_RISE] = high_now && !high_prev_r;
    end

    always_comb
    begin
        evt_clr = '0;
        if (is_wr(bus_req, ADDR_EVT_STATUS))
        begin
            evt_clr = bus_req.wdata;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            evt_status_r <= RESET_EVT;
        end
        else
        begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
        end
    end

    assign irq_out = |(evt_status_r & evt_mask_r);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                ADDR_ENABLE_ONE:   rdata_nxt = enable_one_r;
                ADDR_ENABLE_TWO:   rdata_nxt = enable_two_r;
                ADDR_PRIORITY_ONE: rdata_nxt = priority_one_r;
                ADDR_EVT_STATUS:   rdata_nxt = evt_status_r;
                ADDR_EVT_MASK:     rdata_nxt = evt_mask_r;
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data stand one cycle only, so idle cycles read zero
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            bus_rdata <= 8'h00;
        end
        else
        begin
            bus_rdata <= rdata_nxt;
        end
    end

endmodule

// file: verif/eiep_checker.sv
`timescale 1ns/10ps
module eiep_checker
    import eiep_pkg::*;
(
    input logic               mclk,
    input logic               rst_b,
    input eiep_bus_req_t      bus_req,
    input logic [7:0]         bus_rdata,
    input eiep_flags_t        flags,
    input logic [NUM_SRC-1:0] irq_req,
    input logic [NUM_SRC-1:0] irq_high,
    input logic               any_req_high,
    input logic               any_req_low,
    input logic               irq_out
);
    // ----
    // flags one edge late, the cause of irq_req
    // ----
    eiep_flags_t p_r;
    always_ff @(posedge mclk)
        p_r <= flags;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    t3_gate_a: assert property (irq_req[7] |->
        p_r.timer3_low_overflow_flag | p_r.timer3_high_overflow_flag)
        else $error("timer3 request without flag");
    cmp_gate_a: assert property ((irq_req[6] |->
        p_r.comparator1_rise_flag | p_r.comparator1_fall_flag) and
        (irq_req[5] |-> p_r.comparator0_rise_flag | p_r.comparator0_fall_flag))
        else $error("comparator request without flag");
    src_gate_a: assert property ((irq_req[4:0] & ~{
        p_r.counter_array_flag, p_r.conv_done_flag, p_r.window_cmp_flag,
        p_r.port_match_flag, p_r.smbus_flag}) == 5'h00)
        else $error("request without pending flag");
    unused_one_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) == ADDR_ENABLE_ONE |-> !bus_rdata[1])
        else $error("enable one bit1 read nonzero");
    two_zero_a: assert property ($past(bus_req.rd) &&
        $past(bus_req.addr) == ADDR_ENABLE_TWO |-> bus_rdata[7:2] == 6'h00
        && !bus_rdata[0]) else $error("enable two unused bits nonzero");
    rst_masked_a: assert property ($rose(rst_b) |->
        irq_req == 8'h00 ##1 irq_req == 8'h00) else $error("unmasked at reset");
    prio_sub_a: assert property ((irq_high & ~irq_req) == 8'h00
        && !irq_high[1]) else $error("high level without request");
    any_level_a: assert property (any_req_high == |irq_high &&
        any_req_low == |(irq_req & ~irq_high)) else $error("level summary off");
    cover property (irq_out);
    cover property (any_req_high && any_req_low);
    cover property (irq_req == 8'hFF);
endmodule

// file: verif/eiep_partner.sv
`timescale 1ns/10ps
module eiep_partner
    import eiep_pkg::*;
(
    input  logic        mclk,
    input  logic        rst_b,
    input  logic [10:0] ev,
    output eiep_flags_t flags
);
    // ----
    // peripheral flags: level, held until the source drops them
    // ----
    always_ff @(posedge mclk)
        flags <= rst_b ? eiep_flags_t'(ev) : '0;
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import eiep_pkg::*;
    logic          mclk = 0;
    logic          rst_b = 0;
    eiep_bus_req_t bus_req = '0;
    logic [10:0]   ev = '0;
    eiep_flags_t   flags;
    logic [7:0]    bus_rdata, irq_req, irq_high;
    logic          any_req_high, any_req_low, irq_out;
    int            err_count = 0, num_checks = 0, cyc = 0;
    int            map [11] = '{7, 7, 6, 6, 5, 5, 4, 3, 2, 0, 1};
    eiep_partner u_far (.mclk(mclk), .rst_b(rst_b), .ev(ev), .flags(flags));
    eiep_top DUT (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .flags(flags), .irq_req(irq_req),
        .irq_high(irq_high), .any_req_high(any_req_high),
        .any_req_low(any_req_low), .irq_out(irq_out));
    // ----
    // bus master, gaps between strobes keep one assignment a step
    // ----
    task automatic chk(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge mclk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1 chk(bus_rdata, exp);
    endtask
    task automatic wt();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic fl(input logic [10:0] v);
        @(posedge mclk);
        ev <= v;
        wt();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
        forever #12.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        rd(ADDR_ENABLE_ONE, 8'h00);
        rd(ADDR_ENABLE_TWO, 8'h00);
        rd(ADDR_PRIORITY_ONE, 8'h00);
        fl(11'h7FF);
        chk(irq_req, 8'h00);
        $display("test reset done");
        wr(ADDR_ENABLE_ONE, 8'hFF);
        rd(ADDR_ENABLE_ONE, 8'hFD);
        wr(ADDR_ENABLE_TWO, 8'hFF);
        rd(ADDR_ENABLE_TWO, 8'h02);
        chk(irq_req, 8'hFF);
        for (int b = 0; b < 8; b++)
        begin
            wr(ADDR_ENABLE_ONE, 8'h01 << b);
            wt();
            chk(irq_req, (8'h01 << b) & 8'hFD | 8'h02);
        end
        wr(ADDR_ENABLE_ONE, 8'hFD);
        for (int i = 0; i < 11; i++)
        begin
            fl(11'h400 >> i);
            chk(irq_req, 8'h01 << map[i]);
        end
        $display("test gating done");
        fl(11'h7FF);
        wr(ADDR_PRIORITY_ONE, 8'hFF);
        rd(ADDR_PRIORITY_ONE, 8'hFD);
        wt();
        chk(irq_high, 8'hFD);
        chk({6'h00, any_req_high, any_req_low}, 8'h03);
        $display("test priority done");
        fl(11'h000);
        wr(ADDR_EVT_STATUS, 8'h03);
        fl(11'h7FF);
        chk({7'h00, irq_out}, 8'h00);
        rd(ADDR_EVT_STATUS, 8'h03);
        wr(ADDR_EVT_MASK, 8'h01);
        wt();
        chk({7'h00, irq_out}, 8'h01);
        wr(ADDR_EVT_STATUS, 8'h01);
        wt();
        chk({7'h00, irq_out}, 8'h00);
        rd(ADDR_EVT_STATUS, 8'h02);
        wr(ADDR_EVT_MASK, 8'h02);
        wt();
        chk({7'h00, irq_out}, 8'h01);
        wr(ADDR_EVT_STATUS, 8'h02);
        wt();
        chk({7'h00, irq_out}, 8'h00);
        rd(8'h10, 8'h00);
        $display("test interrupt done");
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rd(ADDR_ENABLE_ONE, 8'h00);
        rd(ADDR_PRIORITY_ONE, 8'h00);
        chk(irq_req, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule
bind eiep_top eiep_checker u_chk (.mclk(mclk), .rst_b(rst_b),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .flags(flags),
    .irq_req(irq_req), .irq_high(irq_high), .any_req_high(any_req_high),
    .any_req_low(any_req_low), .irq_out(irq_out));
